// *** hw/pdcs_defs.svh ***
`ifndef PDCS_DEFS_SVH
`define PDCS_DEFS_SVH
// register address
`define PDCS_ADDR_W 8
`define PDCS_DCS_OFF 8'he8
// control half field positions
`define PDCS_EN_LSB 0
`define PDCS_EN_MSB 3
`define PDCS_RELAX_BIT 4
`define PDCS_MPS_LSB 5
`define PDCS_MPS_MSB 7
`define PDCS_ETAG_BIT 8
`define PDCS_PHANT_BIT 9
`define PDCS_AUXPM_BIT 10
`define PDCS_NOSNP_BIT 11
`define PDCS_MRRS_LSB 12
`define PDCS_MRRS_MSB 14
// status half field positions
`define PDCS_DET_LSB 16
`define PDCS_DET_MSB 19
`define PDCS_AUXDET_BIT 20
`define PDCS_TRPND_BIT 21
// values
`define PDCS_MPS_SUP 3'h1
`define PDCS_MPS_RST 3'h0
`define PDCS_MRRS_VAL 3'h0
`define PDCS_EN_RST 4'h0
`define PDCS_AUXPM_RST 1'b0
`define PDCS_AUXDET_RST 1'b1
`define PDCS_RDATA_IDLE 32'h0
`define PDCS_NUM_ERR 4
`endif

// *** hw/pdcs_err_flag.sv ***
`timescale 1ns/1ns
module pdcs_err_flag (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// set by detector, cleared by software
	input wire logic set,
	input wire logic clr,
	// sticky flag
	output logic flag
);
	logic flag_reg;
	logic flag_next;

	// set wins over clear
	always_comb begin
		flag_next = set | (flag_reg & ~clr);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag = flag_reg;
endmodule // pdcs_err_flag

// *** hw/pdcs_pkg.sv ***
package pdcs_pkg;
	// one bit per error class, bit 0 correctable
	typedef struct packed {
		logic ur;
		logic fe;
		logic nf;
		logic ce;
	} pdcs_err_t;
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} pdcs_req_t;
endpackage

// *** hw/pdcs_regs.sv ***
`timescale 1ns/1ns
`include "pdcs_defs.svh"
module pdcs_regs (
	// clock and resets
	input wire logic clock,
	input wire logic arst_n,
	input wire logic por_arst_n,
	// register port
	input wire pdcs_pkg::pdcs_req_t req,
	output logic [31:0] rdata,
	// error detectors, one-cycle pulses
	input wire pdcs_pkg::pdcs_err_t err_det,
	// aux power presence pin
	input wire logic aux_pwr_present,
	// report requests to message logic
	output pdcs_pkg::pdcs_err_t err_report,
	// control values to the port
	output pdcs_pkg::pdcs_err_t err_en,
	output logic [2:0] max_payload,
	output logic aux_pm_en
);
	logic [3:0] en_reg;
	logic [2:0] mps_reg;
	logic [2:0] mps_next;
	logic aux_pm_reg;
	logic aux_meta_reg;
	logic aux_sync_reg;
	logic [3:0] flags;
	logic [3:0] report_reg;
	logic [31:0] rdata_reg;
	logic [15:0] ctrl_word;
	logic [15:0] sts_word;
	logic wr_hit;
	logic rd_hit;
	logic [2:0] mps_wr;
	logic [3:0] w1c;

	// address decode
	function automatic logic dcs_hit(input logic [`PDCS_ADDR_W-1:0] a);
		return a == `PDCS_DCS_OFF;
	endfunction

	assign wr_hit = req.wr & dcs_hit(req.addr);
	assign rd_hit = req.rd & dcs_hit(req.addr);
	assign mps_wr = req.wdata[`PDCS_MPS_MSB:`PDCS_MPS_LSB];
	assign w1c = req.wdata[`PDCS_DET_MSB:`PDCS_DET_LSB];

	// reporting enables
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			en_reg <= `PDCS_EN_RST;
		end else if (wr_hit) begin
			en_reg <= req.wdata[`PDCS_EN_MSB:`PDCS_EN_LSB];
		end
	end

	// payload size with clamping
	always_comb begin
		mps_next = (mps_wr > `PDCS_MPS_SUP) ? `PDCS_MPS_SUP : mps_wr;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mps_reg <= `PDCS_MPS_RST;
		end else if (wr_hit) begin
			mps_reg <= mps_next;
		end
	end

	// sticky aux power enable, power-on reset only
	always_ff @(posedge clock or negedge por_arst_n) begin
		if (!por_arst_n) begin
			aux_pm_reg <= `PDCS_AUXPM_RST;
		end else if (wr_hit) begin
			aux_pm_reg <= req.wdata[`PDCS_AUXPM_BIT];
		end
	end

	// aux power pin synchroniser
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			aux_meta_reg <= `PDCS_AUXDET_RST;
			aux_sync_reg <= `PDCS_AUXDET_RST;
		end else begin
			aux_meta_reg <= aux_pwr_present;
			aux_sync_reg <= aux_meta_reg;
		end
	end

	// error detected flags
	genvar gi;
	generate
		for (gi = 0; gi < `PDCS_NUM_ERR; gi++) begin : g_flag
			pdcs_err_flag u_flag (
				.clock(clock),
				.arst_n(arst_n),
				.set(err_det[gi]),
				.clr(wr_hit & w1c[gi]),
				.flag(flags[gi])
			);
		end
	endgenerate

	// report pulses
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			report_reg <= 4'h0;
		end else begin
			report_reg <= err_det & en_reg;
		end
	end

	// read-back words
	always_comb begin
		ctrl_word = 16'h0;
		ctrl_word[`PDCS_EN_MSB:`PDCS_EN_LSB] = en_reg;
		ctrl_word[`PDCS_RELAX_BIT] = 1'b0;
		ctrl_word[`PDCS_MPS_MSB:`PDCS_MPS_LSB] = mps_reg;
		ctrl_word[`PDCS_PHANT_BIT:`PDCS_ETAG_BIT] = 2'h0;
		ctrl_word[`PDCS_AUXPM_BIT] = aux_pm_reg;
		ctrl_word[`PDCS_NOSNP_BIT] = 1'b0;
		ctrl_word[`PDCS_MRRS_MSB:`PDCS_MRRS_LSB] = `PDCS_MRRS_VAL;
		sts_word = 16'h0;
		sts_word[`PDCS_DET_MSB-16:0] = flags;
		sts_word[`PDCS_AUXDET_BIT-16] = aux_sync_reg;
		sts_word[`PDCS_TRPND_BIT-16] = 1'b0;
	end

	// read data in the cycle after the strobe only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= `PDCS_RDATA_IDLE;
		end else if (rd_hit) begin
			rdata_reg <= {sts_word, ctrl_word};
		end else begin
			rdata_reg <= `PDCS_RDATA_IDLE;
		end
	end

	assign rdata = rdata_reg;
	assign err_report = report_reg;
	assign err_en = en_reg;
	assign max_payload = mps_reg;
	assign aux_pm_en = aux_pm_reg;

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	property p_en_write;
		wr_hit |=> en_reg == $past(req.wdata[3:0]);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable bits not written");

	property p_en_hold;
		!wr_hit |=> $stable(en_reg);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("enable bits changed without write");

	property p_ro_ctrl;
		rd_hit |=> (rdata[4] == 1'b0) && (rdata[9:8] == 2'h0) && (rdata[11] == 1'b0);
	endproperty
	a_ro_ctrl: assert property (p_ro_ctrl) else $error("read-only control bit not zero");

	property p_mrrs_zero;
		rd_hit |=> rdata[14:12] == 3'h0 && rdata[15] == 1'b0;
	endproperty
	a_mrrs_zero: assert property (p_mrrs_zero) else $error("read request size not zero");

	property p_mps_store;
		wr_hit && (mps_wr <= 3'h1) |=> max_payload == $past(mps_wr);
	endproperty
	a_mps_store: assert property (p_mps_store) else $error("payload size not stored");

	property p_mps_clamp;
		wr_hit && (mps_wr > 3'h1) |=> max_payload == 3'h1;
	endproperty
	a_mps_clamp: assert property (p_mps_clamp) else $error("payload size not clamped");

	property p_mps_bound;
		max_payload <= 3'h1;
	endproperty
	a_mps_bound: assert property (p_mps_bound) else $error("payload size above supported");

	property p_aux_pm;
		disable iff (!por_arst_n) !wr_hit |=> $stable(aux_pm_en);
	endproperty
	a_aux_pm: assert property (p_aux_pm) else $error("aux power enable changed without write");

	property p_flag_set;
		(err_det != 4'h0) |=> (flags & $past(err_det)) == $past(err_det);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("error flag not set");

	property p_flag_clear;
		wr_hit |=> (flags & $past(w1c & ~err_det)) == 4'h0;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("error flag not cleared");

	property p_flag_hold;
		(err_det == 4'h0) && !(wr_hit && w1c != 4'h0) |=> $stable(flags);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("error flag changed by itself");

	property p_set_wins;
		wr_hit && ((w1c & err_det) != 4'h0) |=> (flags & $past(w1c & err_det)) == $past(w1c & err_det);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost on simultaneous clear");

	property p_aux_det;
		aux_pwr_present [*3] |=> rdata_reg[20] == 1'b1 || !$past(rd_hit);
	endproperty
	a_aux_det: assert property (p_aux_det) else $error("aux power detected not shown");

	property p_trpnd;
		rd_hit |=> rdata[21] == 1'b0 && rdata[31:22] == 10'h0;
	endproperty
	a_trpnd: assert property (p_trpnd) else $error("transactions pending not zero");

	property p_rd_idle;
		!rd_hit |=> rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

	property p_rd_flags;
		rd_hit |=> rdata[19:16] == $past(flags);
	endproperty
	a_rd_flags: assert property (p_rd_flags) else $error("read data flags mismatch");

	property p_report;
		1'b1 |=> err_report == $past(err_det & en_reg);
	endproperty
	a_report: assert property (p_report) else $error("report pulse mismatch");

	property p_report_gated;
		(err_det & en_reg) == 4'h0 |=> err_report == 4'h0;
	endproperty
	a_report_gated: assert property (p_report_gated) else $error("report without enabled error");

	// read-back and refused access
	property p_rd_en;
		rd_hit |=> rdata[`PDCS_EN_MSB:`PDCS_EN_LSB] == $past(err_en);
	endproperty
	a_rd_en: assert property (p_rd_en) else $error("read data enables mismatch");

	property p_rd_mps;
		rd_hit |=> rdata[`PDCS_MPS_MSB:`PDCS_MPS_LSB] == $past(max_payload);
	endproperty
	a_rd_mps: assert property (p_rd_mps) else $error("read data payload size mismatch");

	property p_rd_auxpm;
		rd_hit |=> rdata[`PDCS_AUXPM_BIT] == $past(aux_pm_en);
	endproperty
	a_rd_auxpm: assert property (p_rd_auxpm) else $error("read data aux enable mismatch");

	property p_rd_auxdet;
		rd_hit |=> rdata[`PDCS_AUXDET_BIT] == $past(aux_sync_reg);
	endproperty
	a_rd_auxdet: assert property (p_rd_auxdet) else $error("read data aux detected mismatch");

	property p_rd_refused;
		req.rd && !dcs_hit(req.addr) |=> rdata == `PDCS_RDATA_IDLE;
	endproperty
	a_rd_refused: assert property (p_rd_refused) else $error("unmapped read not zero");

	property p_wr_refused;
		req.wr && !dcs_hit(req.addr) && (err_det == 4'h0) |=> $stable(err_en) && $stable(max_payload) && $stable(flags);
	endproperty
	a_wr_refused: assert property (p_wr_refused) else $error("unmapped write changed state");

	// hold and sticky behaviour
	property p_mps_hold;
		!wr_hit |=> $stable(max_payload);
	endproperty
	a_mps_hold: assert property (p_mps_hold) else $error("payload size changed without write");

	property p_aux_write;
		disable iff (!por_arst_n) wr_hit |=> aux_pm_en == $past(req.wdata[`PDCS_AUXPM_BIT]);
	endproperty
	a_aux_write: assert property (p_aux_write) else $error("aux power enable not written");

	property p_aux_keep;
		disable iff (!por_arst_n) !arst_n && !wr_hit |=> $stable(aux_pm_en);
	endproperty
	a_aux_keep: assert property (p_aux_keep) else $error("aux power enable lost in config reset");

	property p_aux_sync;
		1'b1 |=> aux_sync_reg == $past(aux_meta_reg);
	endproperty
	a_aux_sync: assert property (p_aux_sync) else $error("aux power synchroniser skipped a stage");

	property p_flag_noen;
		(err_det & ~en_reg) != 4'h0 |=> (flags & $past(err_det & ~en_reg)) == $past(err_det & ~en_reg);
	endproperty
	a_flag_noen: assert property (p_flag_noen) else $error("disabled error not logged");

	property p_flag_stay;
		(flags != 4'h0) && !wr_hit |=> (flags & $past(flags)) == $past(flags);
	endproperty
	a_flag_stay: assert property (p_flag_stay) else $error("error flag dropped without write");

	// scenarios
	property p_cov_clamp;
		wr_hit && mps_wr == 3'h5;
	endproperty
	c_cov_clamp: cover property (p_cov_clamp);

	property p_cov_race;
		wr_hit && ((w1c & err_det) != 4'h0);
	endproperty
	c_cov_race: cover property (p_cov_race);

	property p_cov_report;
		(err_det.fe && err_en.fe) ##1 err_report.fe;
	endproperty
	c_cov_report: cover property (p_cov_report);

	property p_cov_clear;
		flags[0] ##1 (wr_hit && w1c[0]) ##1 !flags[0];
	endproperty
	c_cov_clear: cover property (p_cov_clear);

	property p_cov_unmapped;
		req.wr && !dcs_hit(req.addr);
	endproperty
	c_cov_unmapped: cover property (p_cov_unmapped);
endmodule // pdcs_regs

// *** verif/pcie_device_control_status_tb_top.sv ***
`timescale 1ns/1ns
`include "pdcs_defs.svh"
module pcie_device_control_status_tb_top;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic por_arst_n = 1'b0;
	logic aux_pwr_present = 1'b1;
	pdcs_pkg::pdcs_err_t err_det = '0;
	pdcs_pkg::pdcs_req_t req;
	logic [31:0] rdata;
	pdcs_pkg::pdcs_err_t err_report;
	pdcs_pkg::pdcs_err_t err_en;
	logic [2:0] max_payload;
	logic aux_pm_en;
	int n_fail = 0;
	int cmp_count = 0;

	always #4 clock = ~clock;

	pdcs_regs i_pdcs_regs (.clock(clock), .arst_n(arst_n), .por_arst_n(por_arst_n), .req(req), .rdata(rdata),
		.err_det(err_det), .aux_pwr_present(aux_pwr_present), .err_report(err_report), .err_en(err_en),
		.max_payload(max_payload), .aux_pm_en(aux_pm_en));
	pdcs_host_model i_pdcs_host_model (.clock(clock), .req(req), .rdata(rdata));

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		i_pdcs_host_model.rd(a, d);
		chk("read word", d, exp);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one-cycle detector pulse, report checked in the cycle after
	task automatic pulse(input pdcs_pkg::pdcs_err_t b, input pdcs_pkg::pdcs_err_t e);
		err_det <= b;
		@(posedge clock);
		err_det <= '0;
		@(posedge clock);
		chk("report", 32'(err_report), 32'(e));
		@(posedge clock);
		chk("report end", 32'(err_report), 32'h0);
	endtask

	task automatic t_reset();
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		por_arst_n <= 1'b1;
		@(posedge clock);
		rchk(`PDCS_DCS_OFF, 32'h0010_0000);
		chk("enables", 32'(err_en), 32'h0);
		chk("payload", 32'(max_payload), 32'h0);
		chk("aux enable", 32'(aux_pm_en), 32'h0);
		$display("test reset done");
	endtask

	task automatic t_ctrl();
		i_pdcs_host_model.wr(`PDCS_DCS_OFF, 32'h0000_ffff);
		rchk(`PDCS_DCS_OFF, 32'h0010_042f);
		chk("enables", 32'(err_en), 32'hf);
		chk("aux enable", 32'(aux_pm_en), 32'h1);
		for (int v = 0; v < 8; v++) begin
			i_pdcs_host_model.wr(`PDCS_DCS_OFF, 32'(v) << 5);
			rchk(`PDCS_DCS_OFF, 32'h0010_0000 | (32'((v > 1) ? 1 : v) << 5));
			chk("payload", 32'(max_payload), 32'((v > 1) ? 1 : v));
		end
		$display("test control done");
	endtask

	task automatic t_unmapped();
		i_pdcs_host_model.wr(`PDCS_DCS_OFF, 32'h0000_000f);
		i_pdcs_host_model.wr(8'he4, 32'h0000_0000);
		i_pdcs_host_model.wr(8'hec, 32'h0000_ffff);
		rchk(`PDCS_DCS_OFF, 32'h0010_000f);
		rchk(8'he4, 32'h0);
		$display("test unmapped done");
	endtask

	task automatic t_flags();
		pdcs_pkg::pdcs_err_t b;
		for (int i = 0; i < 4; i++) begin
			b = pdcs_pkg::pdcs_err_t'(4'h1 << i);
			i_pdcs_host_model.wr(`PDCS_DCS_OFF, 32'h0);
			pulse(b, '0);
			rchk(`PDCS_DCS_OFF, 32'h0010_0000 | (32'(b) << 16));
			i_pdcs_host_model.wr(`PDCS_DCS_OFF, 32'(b));
			pulse(b, b);
			err_det <= b;
			fork
				i_pdcs_host_model.wr(`PDCS_DCS_OFF, 32'(b) << 16);
				begin
					@(posedge clock);
					err_det <= '0;
				end
			join
			rchk(`PDCS_DCS_OFF, 32'h0010_0000 | (32'(b) << 16));
			i_pdcs_host_model.wr(`PDCS_DCS_OFF, 32'(b) << 16);
			rchk(`PDCS_DCS_OFF, 32'h0010_0000);
		end
		$display("test flags done");
	endtask

	task automatic t_sticky();
		i_pdcs_host_model.wr(`PDCS_DCS_OFF, 32'h0000_0403);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		chk("aux enable", 32'(aux_pm_en), 32'h1);
		rchk(`PDCS_DCS_OFF, 32'h0010_0400);
		por_arst_n <= 1'b0;
		@(posedge clock);
		por_arst_n <= 1'b1;
		@(posedge clock);
		chk("aux enable", 32'(aux_pm_en), 32'h0);
		rchk(`PDCS_DCS_OFF, 32'h0010_0000);
		$display("test sticky done");
	endtask

	task automatic t_auxpin();
		aux_pwr_present <= 1'b0;
		repeat (3) @(posedge clock);
		rchk(`PDCS_DCS_OFF, 32'h0);
		aux_pwr_present <= 1'b1;
		repeat (3) @(posedge clock);
		rchk(`PDCS_DCS_OFF, 32'h0010_0000);
		$display("test aux pin done");
	endtask

	initial begin
		#400000;
		n_fail++;
		close_out();
	end

	initial begin
		t_reset();
		t_ctrl();
		t_unmapped();
		t_flags();
		t_sticky();
		t_auxpin();
		close_out();
	end
endmodule // pcie_device_control_status_tb_top

// *** verif/pdcs_host_model.sv ***
`timescale 1ns/1ns
module pdcs_host_model (
	// clock
	input wire logic clock,
	// register port toward the block
	output pdcs_pkg::pdcs_req_t req,
	input wire logic [31:0] rdata
);
	initial req = '0;

	// one-cycle write strobe, then idle with inverted address and data
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		@(posedge clock);
	endtask

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: req.wdata};
		@(posedge clock);
		d = rdata;
	endtask
endmodule // pdcs_host_model
